// ### rtl/bds_pkg.sv
// Constants and types shared by the backlight dim and fade sequencer
package bds_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_DIM_DELAY  = 8'h07;
	localparam logic [7:0] ADDR_FADE_RATES = 8'h08;
	localparam logic [7:0] RESET_DIM_DELAY  = 8'h00;
	localparam logic [7:0] RESET_FADE_RATES = 8'h00;
	localparam logic [7:0] READ_NONE        = 8'h00;
	localparam int DIM_MSB     = 6;
	localparam int FADE_OUT_LSB = 4;
	localparam int FADE_OUT_MSB = 7;
	localparam int FADE_IN_MSB  = 3;

	// ==========================================================
	// Codes and levels
	localparam logic [6:0] DELAY_OFF  = 7'h00;
	localparam logic [6:0] LEVEL_ZERO = 7'h00;
	localparam logic [6:0] LEVEL_HALF = 7'h40;
	localparam logic [6:0] LEVEL_STEP = 7'h01;
	localparam logic [3:0] RATE_FAST  = 4'h0;
	localparam logic [1:0] LAW_LINEAR = 2'h0;
	localparam logic [1:0] LAW_SQUARE = 2'h1;
	localparam logic [1:0] LAW_CUBIC_LOW  = 2'h2;
	localparam logic [1:0] LAW_CUBIC_HIGH = 2'h3;

	// ==========================================================
	// Timing
	localparam int CLK_KHZ      = 50000;
	localparam int SECOND_MS    = 1000;
	localparam int RAMP_UNIT_MS = 100;
	// Full scale (30 mA) is DAC code 127
	localparam int FULL_SCALE   = 127;
	localparam int TICK_CYCLES_DEF = SECOND_MS * CLK_KHZ;
	localparam int STEP_BASE_DEF   = RAMP_UNIT_MS * CLK_KHZ / FULL_SCALE;

	// ==========================================================
	// Sequencer states, Gray along off, rise, max, fall, dim
	typedef enum logic [2:0] {
		BDS_OFF  = 3'h0,
		BDS_RISE = 3'h1,
		BDS_MAX  = 3'h3,
		BDS_FALL = 3'h2,
		BDS_DIM  = 3'h6
	} bds_state_type;

endpackage

// ### rtl/bds_sequencer.sv
// Backlight dim timeout and fade in/out sequencer with its two registers
//
// Summary of operation
// RULE_01: After a nonzero dim delay expires, backlight drops to the dim level.
// RULE_02: Dim delay counting starts when the backlight reaches maximum current.
// RULE_03: Seven-bit dim delay; zero disables, code N waits N seconds.
// RULE_04: Nonzero fade-out code ramps current down to dim or off at that rate.
// RULE_05: Fade-out code zero changes current quickly, within about 100 ms.
// RULE_06: Fade-out codes give 0.1 s, 0.3 s steps to 3.0 s, then 4.5-5.5 s.
// RULE_07: Fade-out times are full scale; smaller spans take proportionally less.
// RULE_08: Nonzero fade-in code ramps current up to maximum on turn-on.
// RULE_09: Fade-in code zero raises current quickly, within about 100 ms.
// RULE_10: Fade-in codes give 0.1, 0.3, 0.6, 0.9 s up to 5.5 s.
// RULE_11: Fade-in times are full scale; smaller spans finish proportionally sooner.
// RULE_12: With dim enabled, off delay starts after dim expiry, then backlight off.
// RULE_13: Two-bit law picks linear, square, or two nonlinear step-time profiles; the code steps square exactly as linear.
// RULE_14: Unprinted rate codes share one table: 3.5 s, 4.0 s, else fade-out.
// RULE_15: Delays use a one-second tick that restarts with the delay sequence.
`timescale 1ns/1ps
module bds_sequencer #(
	parameter int TICK_CYCLES = bds_pkg::TICK_CYCLES_DEF,
	parameter int STEP_BASE   = bds_pkg::STEP_BASE_DEF
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Register port from the serial interface
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_write,
	output logic      [7:0]           reg_rdata,
	// Backlight control from the rest of the device
	input  wire logic                 bl_on,
	input  wire logic [6:0]           max_level,
	input  wire logic [6:0]           dim_level,
	input  wire logic [6:0]           off_delay_code,
	input  wire logic [1:0]           law,
	// Backlight drive and status
	output logic      [6:0]           bl_level,
	output bds_pkg::bds_state_type    bl_state
);
	import bds_pkg::*;

	// ==========================================================
	// Rate table in tenths of a second, shared by both directions
	function automatic logic [5:0] rate_tenths(input logic [3:0] code);
		logic [5:0] t;
		t = 6'h01;
		case (code)
			4'h0: t = 6'h01;
			4'h1: t = 6'h03;
			4'h2: t = 6'h06;
			4'h3: t = 6'h09;
			4'h4: t = 6'h0C;
			4'h5: t = 6'h0F;
			4'h6: t = 6'h12;
			4'h7: t = 6'h15;
			4'h8: t = 6'h18;
			4'h9: t = 6'h1B;
			4'hA: t = 6'h1E;
			4'hB: t = 6'h23;
			4'hC: t = 6'h28;
			4'hD: t = 6'h2D;
			4'hE: t = 6'h32;
			default: t = 6'h37;
		endcase
		return t; // [RULE_06] [RULE_10] [RULE_14]
	endfunction

	// ==========================================================
	// Registers
	logic [6:0] dim_delay_code;
	logic [3:0] fade_out_rate;
	logic [3:0] fade_in_rate;
	logic [6:0] next_dim_delay_code;
	logic [3:0] next_fade_out_rate;
	logic [3:0] next_fade_in_rate;
	logic [7:0] next_reg_rdata;

	always_comb begin
		next_dim_delay_code = dim_delay_code;
		next_fade_out_rate  = fade_out_rate;
		next_fade_in_rate   = fade_in_rate;
		next_reg_rdata      = READ_NONE;
		if (reg_write && reg_addr == ADDR_DIM_DELAY) begin
			next_dim_delay_code = reg_wdata[DIM_MSB:0]; // [RULE_03]
		end else if (reg_write && reg_addr == ADDR_FADE_RATES) begin
			next_fade_out_rate = reg_wdata[FADE_OUT_MSB:FADE_OUT_LSB];
			next_fade_in_rate  = reg_wdata[FADE_IN_MSB:0];
		end
		// Reserved top bit of the dim register reads zero
		if (reg_addr == ADDR_DIM_DELAY) begin
			next_reg_rdata = {1'b0, dim_delay_code};
		end else if (reg_addr == ADDR_FADE_RATES) begin
			next_reg_rdata = {fade_out_rate, fade_in_rate};
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dim_delay_code <= RESET_DIM_DELAY[DIM_MSB:0];
			fade_out_rate  <= RESET_FADE_RATES[FADE_OUT_MSB:FADE_OUT_LSB];
			fade_in_rate   <= RESET_FADE_RATES[FADE_IN_MSB:0];
			reg_rdata      <= READ_NONE;
		end else begin
			dim_delay_code <= next_dim_delay_code;
			fade_out_rate  <= next_fade_out_rate;
			fade_in_rate   <= next_fade_in_rate;
			reg_rdata      <= next_reg_rdata;
		end
	end

	// ==========================================================
	// Step period: one DAC code per period, so a shorter span is
	// automatically a shorter fade
	logic [3:0]  rate_sel;
	logic [23:0] step_limit;
	logic        slow_half;

	always_comb begin
		rate_sel = (bl_state == BDS_FALL) ? fade_out_rate : fade_in_rate;
		step_limit = 24'(rate_tenths(rate_sel)) * 24'(STEP_BASE); // [RULE_07] [RULE_11]
		// Nonlinear profiles linger twice as long in one half of the range
		slow_half = (law == LAW_CUBIC_LOW  && bl_level <  LEVEL_HALF) ||
		            (law == LAW_CUBIC_HIGH && bl_level >= LEVEL_HALF);
		if (slow_half) begin
			step_limit = step_limit << 1; // [RULE_13]
		end
	end

	// ==========================================================
	// Sequencer
	logic [23:0] step_cnt;
	logic [25:0] tick_cnt;
	logic [6:0]  sec_cnt;
	logic [6:0]  target;
	logic        off_phase;
	logic        bl_on_q;
	bds_state_type next_bl_state;
	logic [6:0]  next_bl_level;
	logic [23:0] next_step_cnt;
	logic [25:0] next_tick_cnt;
	logic [6:0]  next_sec_cnt;
	logic [6:0]  next_target;
	logic        next_off_phase;
	logic        step_due;
	logic        dim_due;
	logic        off_due;

	always_comb begin
		next_bl_state  = bl_state;
		next_bl_level  = bl_level;
		next_step_cnt  = step_cnt + 24'h000001;
		next_tick_cnt  = 26'h0000000;
		next_sec_cnt   = 7'h00;
		next_target    = target;
		next_off_phase = off_phase;
		step_due = (step_cnt >= step_limit - 24'h000001);
		dim_due  = !off_phase && dim_delay_code != DELAY_OFF &&
		           sec_cnt == dim_delay_code; // [RULE_01] [RULE_03]
		off_due  = off_phase && off_delay_code != DELAY_OFF &&
		           sec_cnt == off_delay_code;
		if (step_due) begin
			next_step_cnt = 24'h000000;
		end
		// One-second tick runs only in the max and dim states, even with no delay set
		if (bl_state == BDS_MAX || bl_state == BDS_DIM) begin
			next_tick_cnt = tick_cnt + 26'h0000001;
			next_sec_cnt  = sec_cnt;
			if (tick_cnt == 26'(TICK_CYCLES - 1)) begin
				next_tick_cnt = 26'h0000000;
				next_sec_cnt  = sec_cnt + 7'h01; // [RULE_15]
			end
		end
		case (bl_state)
			BDS_OFF: begin
				next_step_cnt = 24'h000000;
				if (bl_on && !bl_on_q) begin
					next_bl_state = BDS_RISE;
				end
			end
			BDS_RISE: begin
				if (bl_level == max_level) begin
					next_bl_state  = BDS_MAX; // [RULE_02]
					next_off_phase = (dim_delay_code == DELAY_OFF);
				end else if (step_due && bl_level < max_level) begin
					next_bl_level = bl_level + LEVEL_STEP; // [RULE_08] [RULE_09]
				end else if (step_due) begin
					next_bl_level = bl_level - LEVEL_STEP;
				end
			end
			BDS_MAX: begin
				if (bl_level != max_level) begin
					next_bl_state = BDS_RISE;
				end else if (dim_due) begin
					next_bl_state  = BDS_FALL;
					next_target    = dim_level;
					next_off_phase = 1'b1; // [RULE_12]
				end else if (off_due) begin
					next_bl_state = BDS_FALL;
					next_target   = LEVEL_ZERO;
				end
			end
			BDS_FALL: begin
				if (bl_level == target) begin
					next_bl_state = (target == LEVEL_ZERO) ? BDS_OFF : BDS_DIM;
				end else if (step_due && bl_level > target) begin
					next_bl_level = bl_level - LEVEL_STEP; // [RULE_04] [RULE_05]
				end else if (step_due) begin
					next_bl_level = bl_level + LEVEL_STEP;
				end
			end
			BDS_DIM: begin
				if (off_due) begin
					next_bl_state = BDS_FALL; // [RULE_12]
					next_target   = LEVEL_ZERO;
				end
			end
			default: next_bl_state = BDS_OFF;
		endcase
		// Turn-off and turn-on override any pending delay; a fade that
		// has just reached zero must still be allowed to settle in off
		if (!bl_on && bl_state != BDS_OFF && next_bl_state != BDS_OFF) begin
			next_bl_state = BDS_FALL;
			next_target   = LEVEL_ZERO;
		end else if (bl_on && !bl_on_q && bl_state != BDS_OFF) begin
			next_bl_state = BDS_RISE; // [RULE_15]
		end
		// Any state change restarts the step period and the delay count
		if (next_bl_state != bl_state) begin
			next_step_cnt = 24'h000000;
			next_tick_cnt = 26'h0000000; // [RULE_15]
			next_sec_cnt  = 7'h00;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			bl_state  <= BDS_OFF;
			bl_level  <= LEVEL_ZERO;
			step_cnt  <= 24'h000000;
			tick_cnt  <= 26'h0000000;
			sec_cnt   <= 7'h00;
			target    <= LEVEL_ZERO;
			off_phase <= 1'b0;
			bl_on_q   <= 1'b0;
		end else begin
			bl_state  <= next_bl_state;
			bl_level  <= next_bl_level;
			step_cnt  <= next_step_cnt;
			tick_cnt  <= next_tick_cnt;
			sec_cnt   <= next_sec_cnt;
			target    <= next_target;
			off_phase <= next_off_phase;
			bl_on_q   <= bl_on;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_dim_arrival: assert property ( // [RULE_01]
		bl_state == BDS_FALL && bl_level == target && target != LEVEL_ZERO
		&& bl_on && !(bl_on && !bl_on_q) |=> bl_state == BDS_DIM)
		else $error("dim level reached but not dimmed");
	a_count_after_max: assert property ( // [RULE_02]
		bl_state != BDS_MAX && bl_state != BDS_DIM |-> sec_cnt == 7'h00)
		else $error("delay counted before maximum reached");
	a_dim_disabled: assert property ( // [RULE_03]
		bl_state == BDS_MAX && dim_delay_code == DELAY_OFF
		&& bl_on && bl_on_q && bl_level == max_level
		|=> bl_state == BDS_MAX || target == LEVEL_ZERO)
		else $error("disabled dim delay left maximum");
	a_fall_down: assert property ( // [RULE_04]
		bl_state == BDS_FALL && bl_level > target && bl_on
		|=> bl_level <= $past(bl_level))
		else $error("fade out raised the level");
	a_fast_fade: assert property ( // [RULE_05]
		bl_state == BDS_FALL && fade_out_rate == RATE_FAST
		&& law == LAW_LINEAR |-> step_limit == 24'(STEP_BASE))
		else $error("fast fade step period wrong");
	a_single_step: assert property ( // [RULE_07]
		bl_state != BDS_OFF && $past(bl_state) != BDS_OFF && bl_on
		&& $past(bl_on) |-> bl_level - $past(bl_level) <= 7'h01
		|| $past(bl_level) - bl_level <= 7'h01)
		else $error("level moved by more than one code");
	a_rise_up: assert property ( // [RULE_08]
		bl_state == BDS_RISE && bl_level < max_level && bl_on
		|=> bl_level >= $past(bl_level))
		else $error("fade in lowered the level");
	a_step_bound: assert property ( // [RULE_14]
		step_cnt < step_limit || $changed(bl_state) || $changed(law)
		|| $changed(bl_level) || $past(reg_write))
		else $error("step counter overran its period");
	a_off_after_dim: assert property ( // [RULE_12]
		bl_state == BDS_DIM |-> off_phase)
		else $error("dim state without off phase");
	a_tick_restart: assert property ( // [RULE_15]
		bl_state == BDS_OFF |-> tick_cnt == 26'h0000000)
		else $error("tick not restarted when off");

	c_reach_max: cover property (bl_state == BDS_RISE ##1 bl_state == BDS_MAX);
	c_reach_dim: cover property (bl_state == BDS_FALL ##1 bl_state == BDS_DIM);
	c_dim_to_off: cover property (bl_state == BDS_DIM ##1 bl_state == BDS_FALL);
	c_fade_off: cover property (bl_state == BDS_FALL ##1 bl_state == BDS_OFF);

endmodule

// ### test/bds_sequencer_tb.sv
// Self-checking bench for the backlight dim and fade sequencer
`timescale 1ns/1ps
module bds_sequencer_tb;
	import bds_pkg::*;
	// Short tick and step so a full sequence fits in a few thousand cycles
	localparam int TICK = 20;
	localparam int SB   = 2;
	localparam int TENTHS [16] = '{1, 3, 6, 9, 12, 15, 18, 21, 24, 27, 30,
		35, 40, 45, 50, 55};
	logic          clock = 1'b0;
	logic          rst = 1'b1;
	logic [7:0]    reg_addr = 8'h00;
	logic [7:0]    reg_wdata = 8'h00;
	logic          reg_write = 1'b0;
	logic [7:0]    reg_rdata;
	logic          bl_on = 1'b0;
	logic [6:0]    max_level = 7'h00;
	logic [6:0]    dim_level = 7'h00;
	logic [6:0]    off_delay_code = 7'h00;
	logic [1:0]    law = LAW_LINEAR;
	logic [6:0]    bl_level;
	bds_state_type bl_state;
	int            n_mismatch = 0;
	int            checked = 0;

	always #10 clock = ~clock;

	bds_sequencer #(.TICK_CYCLES(TICK), .STEP_BASE(SB)) bds_sequencer_i (
		.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
		.bl_on(bl_on), .max_level(max_level), .dim_level(dim_level),
		.off_delay_code(off_delay_code), .law(law), .bl_level(bl_level),
		.bl_state(bl_state));

	// ==========================================================
	// Helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic near(input int n, input int e, input int tol);
		return (n + tol >= e) && (n <= e + tol);
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		@(negedge clock);
		check(reg_rdata, exp);
	endtask

	// Bounded wait; the state compare afterwards catches a hang
	task automatic wait_st(input bds_state_type s, input int lim,
		output int n);
		n = 0;
		while (bl_state !== s && n < lim) begin
			@(negedge clock);
			n++;
		end
		check(8'(bl_state), 8'(s));
	endtask

	task automatic give_verdict;
		$display("mismatches=%0d checks=%0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#1800000;
		n_mismatch++;
		give_verdict;
	end

	// ==========================================================
	// Tests
	initial begin
		int n;
		int p;
		int f;
		logic [3:0] fi;
		logic [3:0] fo;
		logic [6:0] mx;
		logic [6:0] dm;
		logic [6:0] dc;
		logic [7:0] d;
		void'($urandom(32'h6455));
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(ADDR_DIM_DELAY, RESET_DIM_DELAY);
		rd(ADDR_FADE_RATES, RESET_FADE_RATES);
		check({1'b0, bl_level}, 8'h00);
		check(8'(bl_state), 8'(BDS_OFF));
		d = 8'($urandom);
		wr(8'h09, d);
		rd(8'h09, READ_NONE);
		rd(ADDR_FADE_RATES, RESET_FADE_RATES);
		for (int i = 0; i < 6; i++) begin
			fi = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : (i == 2) ? 4'hB : 4'($urandom);
			fo = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : (i == 2) ? 4'hC : 4'($urandom);
			mx = 7'(8 + $urandom % 12);
			dm = 7'(1 + $urandom % (mx - 1));
			dc = (i == 5) ? DELAY_OFF : 7'(1 + $urandom % 2);
			wr(ADDR_FADE_RATES, {fo, fi});
			rd(ADDR_FADE_RATES, {fo, fi});
			wr(ADDR_DIM_DELAY, {1'b1, dc});
			rd(ADDR_DIM_DELAY, {1'b0, dc});
			@(posedge clock);
			max_level <= mx;
			dim_level <= dm;
			off_delay_code <= 7'h01;
			law <= (i < 3) ? LAW_LINEAR : 2'($urandom % 4);
			bl_on <= 1'b1;
			wait_st(BDS_RISE, 4, n);
			// Every level stays below half scale, so only the low
			// nonlinear profile slows these ramps
			f = (law == LAW_CUBIC_LOW) ? 2 : 1;
			p = TENTHS[fi] * SB * f;
			wait_st(BDS_MAX, 4 * mx * p + 40, n);
			check(8'(near(n, mx * p, p + 4)), 8'h01);
			check({1'b0, bl_level}, {1'b0, mx});
			wait_st(BDS_FALL, TICK * 3 + 8, n);
			check(8'(near(n, (dc == 0 ? 1 : dc) * TICK, 4)), 8'h01);
			p = TENTHS[fo] * SB * f;
			if (dc != 0) begin
				wait_st(BDS_DIM, 4 * mx * p + 40, n);
				check(8'(near(n, (mx - dm) * p, p + 4)), 8'h01);
				check({1'b0, bl_level}, {1'b0, dm});
				wait_st(BDS_FALL, TICK + 8, n);
				check(8'(near(n, TICK, 4)), 8'h01);
			end
			wait_st(BDS_OFF, 4 * mx * p + 40, n);
			if (dc != 0)
				check(8'(near(n, dm * p, p + 4)), 8'h01);
			check({1'b0, bl_level}, 8'h00);
			@(posedge clock);
			bl_on <= 1'b0;
		end
		// Turning off in mid-ramp falls straight back to zero
		@(posedge clock);
		bl_on <= 1'b1;
		repeat (30) @(posedge clock);
		bl_on <= 1'b0;
		wait_st(BDS_OFF, 4000, n);
		check({1'b0, bl_level}, 8'h00);
		give_verdict;
	end
endmodule
